// *** shared/cpbv_defs.vh ***
// Overview of operation
// RULE1 - reading the swapped view returns the accumulator with its two bytes exchanged, and it is read-only.
// RULE2 - every reset clears all registers, views and pointers to zero.
// RULE3 - reading the high-byte alias returns the accumulator's current upper byte.
// RULE4 - writing the high-byte alias loads the accumulator's upper byte and keeps its lower byte.
// RULE5 - the read-only sign-extended view is the accumulator low byte with bit 7 copied into the upper eight bits.
// RULE6 - the read-only frame view returns the frame base plus the frame offset.
// RULE7 - data pointer zero is a read/write address that may step after reads and before writes through it.
// RULE8 - data pointer one is a separate pointer with the same stepping as data pointer zero.
// RULE9 - the code pointer is a read/write address that may step after reads and never steps on writes.
// RULE10 - writes to the read-only views change no state.
`ifndef CPBV_DEFS_VH
`define CPBV_DEFS_VH

`define CPBV_DATA_W 16
`define CPBV_BYTE_W 8
`define CPBV_ADDR_W 9
`define CPBV_SIGN_BIT 7

// register addresses: {module[3:0], index[4:0]}
`define CPBV_ADDR_ACC 9'h180
`define CPBV_ADDR_BASE 9'h181
`define CPBV_ADDR_OFST 9'h182
`define CPBV_ADDR_MODE 9'h183
`define CPBV_ADDR_SWAP 9'h1C8
`define CPBV_ADDR_HIGH 9'h1C9
`define CPBV_ADDR_SEXT 9'h1CA
`define CPBV_ADDR_FRAME 9'h1CB
`define CPBV_ADDR_DP0 9'h1E3
`define CPBV_ADDR_DP1 9'h1E7
`define CPBV_ADDR_CPTR 9'h1EB

// pointer step modes, two bits per pointer in the mode register
`define CPBV_STEP_NONE 2'h0
`define CPBV_STEP_INC 2'h1
`define CPBV_STEP_DEC 2'h2
`define CPBV_MODE_W 6
`define CPBV_MODE_DP0_LSB 0
`define CPBV_MODE_DP1_LSB 2
`define CPBV_MODE_CPTR_LSB 4

// pointer select codes
`define CPBV_SEL_DP0 2'h0
`define CPBV_SEL_DP1 2'h1
`define CPBV_SEL_CPTR 2'h2
`define CPBV_NUM_PTR 3

`define CPBV_RST_WORD 16'h0000
`define CPBV_RST_BYTE 8'h00
`define CPBV_RST_MODE 6'h00
`define CPBV_STEP_ONE 16'h0001

`endif

// *** rtl/cpbv_ptr_step.v ***
`timescale 1ns/1ps
`include "cpbv_defs.vh"
module cpbv_ptr_step #(
    parameter WIDTH = 16,
    parameter PRE_WRITE_EN = 1
) (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire load_i,
    input wire [WIDTH-1:0] load_data_i,
    input wire rd_i,
    input wire wr_i,
    input wire [1:0] mode_i,
    output wire [WIDTH-1:0] ptr_o,
    output wire [WIDTH-1:0] access_addr_o
);
    reg [WIDTH-1:0] ptr_q;
    reg [WIDTH-1:0] ptr_d;
    reg [WIDTH-1:0] stepped;
    wire step_en;
    wire pre_write;

    assign step_en = (mode_i == `CPBV_STEP_INC) || (mode_i == `CPBV_STEP_DEC);
    assign pre_write = (PRE_WRITE_EN != 0) && wr_i && step_en;

    always @* begin
        if (mode_i == `CPBV_STEP_DEC) begin
            stepped = ptr_q - `CPBV_STEP_ONE;
        end else begin
            stepped = ptr_q + `CPBV_STEP_ONE;
        end
    end

    // a write uses the already adjusted address, a read the current one
    assign access_addr_o = pre_write ? stepped : ptr_q;
    assign ptr_o = ptr_q;

    always @* begin
        ptr_d = ptr_q;
        if (load_i) begin
            ptr_d = load_data_i;
        end else if (rd_i && step_en) begin
            ptr_d = stepped;
        end else if (pre_write) begin
            ptr_d = stepped;
        end
    end

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ptr_q <= `CPBV_RST_WORD; // RULE2
        end else if (ce_i) begin
            ptr_q <= ptr_d;
        end
    end
endmodule // cpbv_ptr_step

// *** rtl/cpbv_regs.v ***
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "cpbv_defs.vh"
module cpbv_regs #(
    parameter WIDTH = 16
) (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire [8:0] reg_addr_i,
    input wire [WIDTH-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output wire [WIDTH-1:0] reg_rdata_o,
    input wire [1:0] ptr_sel_i,
    input wire ptr_rd_i,
    input wire ptr_wr_i,
    output wire [WIDTH-1:0] mem_addr_o,
    output wire data_mem_rd_o,
    output wire data_mem_wr_o,
    output wire code_mem_rd_o,
    output wire [WIDTH-1:0] accum_o,
    output wire [WIDTH-1:0] frame_addr_o,
    output wire [WIDTH-1:0] data_ptr0_o,
    output wire [WIDTH-1:0] data_ptr1_o,
    output wire [WIDTH-1:0] code_ptr_o
);
    localparam NPTR = `CPBV_NUM_PTR;
    localparam BW = `CPBV_BYTE_W;

    // architectural state
    reg [WIDTH-1:0] acc_q;
    reg [WIDTH-1:0] acc_d;
    reg [WIDTH-1:0] base_q;
    reg [WIDTH-1:0] base_d;
    reg [BW-1:0] ofst_q;
    reg [BW-1:0] ofst_d;
    reg [`CPBV_MODE_W-1:0] mode_q;
    reg [`CPBV_MODE_W-1:0] mode_d;

    // bus answer and memory access outputs
    reg [WIDTH-1:0] rdata_q;
    reg [WIDTH-1:0] rdata_d;
    reg [WIDTH-1:0] mem_addr_q;
    reg [WIDTH-1:0] mem_addr_d;
    reg data_rd_q;
    reg data_wr_q;
    reg code_rd_q;

    // decoded register strobes
    wire wr_acc;
    wire wr_base;
    wire wr_ofst;
    wire wr_mode;
    wire wr_high;
    wire wr_dp0;
    wire wr_dp1;
    wire wr_cptr;

    // views derived from the accumulator and frame registers
    wire [WIDTH-1:0] swapped_view;
    wire [BW-1:0] high_byte_view;
    wire [WIDTH-1:0] sign_ext_view;
    wire [WIDTH-1:0] frame_view;

    // pointer access decode
    wire sel_dp0;
    wire sel_dp1;
    wire sel_cptr;
    wire sel_valid;
    wire [NPTR-1:0] ptr_load;
    wire [NPTR-1:0] ptr_rd;
    wire [NPTR-1:0] ptr_wr;
    wire [NPTR*2-1:0] ptr_mode;
    wire [NPTR*WIDTH-1:0] ptr_flat;
    wire [NPTR*WIDTH-1:0] acc_flat;

    assign wr_acc = reg_wr_i && (reg_addr_i == `CPBV_ADDR_ACC);
    assign wr_base = reg_wr_i && (reg_addr_i == `CPBV_ADDR_BASE);
    assign wr_ofst = reg_wr_i && (reg_addr_i == `CPBV_ADDR_OFST);
    assign wr_mode = reg_wr_i && (reg_addr_i == `CPBV_ADDR_MODE);
    assign wr_high = reg_wr_i && (reg_addr_i == `CPBV_ADDR_HIGH);
    assign wr_dp0 = reg_wr_i && (reg_addr_i == `CPBV_ADDR_DP0);
    assign wr_dp1 = reg_wr_i && (reg_addr_i == `CPBV_ADDR_DP1);
    assign wr_cptr = reg_wr_i && (reg_addr_i == `CPBV_ADDR_CPTR);
    // writes to the swapped, sign-extended and frame views decode to nothing

    assign swapped_view = {acc_q[BW-1:0], acc_q[WIDTH-1:BW]}; // RULE1
    assign high_byte_view = acc_q[WIDTH-1:BW]; // RULE3
    assign sign_ext_view = {{(WIDTH-BW){acc_q[`CPBV_SIGN_BIT]}}, acc_q[BW-1:0]}; // RULE5
    assign frame_view = base_q + {{(WIDTH-BW){1'b0}}, ofst_q}; // RULE6

    // accumulator: full-word write or upper-byte write through the alias
    always @* begin
        acc_d = acc_q;
        if (wr_acc) begin
            acc_d = reg_wdata_i;
        end else if (wr_high) begin
            acc_d = {reg_wdata_i[BW-1:0], acc_q[BW-1:0]}; // RULE4
        end
    end

    always @* begin
        base_d = base_q;
        if (wr_base) begin
            base_d = reg_wdata_i;
        end
    end

    always @* begin
        ofst_d = ofst_q;
        if (wr_ofst) begin
            ofst_d = reg_wdata_i[BW-1:0];
        end
    end

    always @* begin
        mode_d = mode_q;
        if (wr_mode) begin
            mode_d = reg_wdata_i[`CPBV_MODE_W-1:0];
        end
    end

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            acc_q <= `CPBV_RST_WORD; // RULE2
            base_q <= `CPBV_RST_WORD;
            ofst_q <= `CPBV_RST_BYTE;
            mode_q <= `CPBV_RST_MODE;
        end else if (ce_i) begin
            acc_q <= acc_d; // RULE10
            base_q <= base_d;
            ofst_q <= ofst_d;
            mode_q <= mode_d;
        end
    end

    // pointer access select; code 3 is ignored
    assign sel_dp0 = (ptr_sel_i == `CPBV_SEL_DP0);
    assign sel_dp1 = (ptr_sel_i == `CPBV_SEL_DP1);
    assign sel_cptr = (ptr_sel_i == `CPBV_SEL_CPTR);
    assign sel_valid = sel_dp0 || sel_dp1 || sel_cptr;

    assign ptr_load = {wr_cptr, wr_dp1, wr_dp0};
    assign ptr_rd = {sel_cptr && ptr_rd_i, sel_dp1 && ptr_rd_i, sel_dp0 && ptr_rd_i};
    // the code pointer is never written through, only read through
    assign ptr_wr = {1'b0, sel_dp1 && ptr_wr_i, sel_dp0 && ptr_wr_i};
    assign ptr_mode = {mode_q[`CPBV_MODE_CPTR_LSB+1:`CPBV_MODE_CPTR_LSB],
                       mode_q[`CPBV_MODE_DP1_LSB+1:`CPBV_MODE_DP1_LSB],
                       mode_q[`CPBV_MODE_DP0_LSB+1:`CPBV_MODE_DP0_LSB]};

    genvar gi;
    generate
        for (gi = 0; gi < NPTR; gi = gi + 1) begin : g_ptr
            // entries 0 and 1 are data pointers, entry 2 the code pointer
            cpbv_ptr_step #(
                .WIDTH(WIDTH),
                .PRE_WRITE_EN((gi < 2) ? 1 : 0)
            ) u_ptr (
                .core_clk_i(core_clk_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .load_i(ptr_load[gi]),
                .load_data_i(reg_wdata_i),
                .rd_i(ptr_rd[gi]),
                .wr_i(ptr_wr[gi]),
                .mode_i(ptr_mode[gi*2+1:gi*2]),
                .ptr_o(ptr_flat[gi*WIDTH+WIDTH-1:gi*WIDTH]),
                .access_addr_o(acc_flat[gi*WIDTH+WIDTH-1:gi*WIDTH])
            ); // RULE7 RULE8 RULE9
        end
    endgenerate

    assign data_ptr0_o = ptr_flat[WIDTH-1:0];
    assign data_ptr1_o = ptr_flat[2*WIDTH-1:WIDTH];
    assign code_ptr_o = ptr_flat[3*WIDTH-1:2*WIDTH];

    // memory address presented one cycle after the pointer access
    always @* begin
        mem_addr_d = mem_addr_q;
        if (sel_dp0 && (ptr_rd_i || ptr_wr_i)) begin
            mem_addr_d = acc_flat[WIDTH-1:0];
        end else if (sel_dp1 && (ptr_rd_i || ptr_wr_i)) begin
            mem_addr_d = acc_flat[2*WIDTH-1:WIDTH];
        end else if (sel_cptr && ptr_rd_i) begin
            mem_addr_d = acc_flat[3*WIDTH-1:2*WIDTH];
        end
    end

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mem_addr_q <= `CPBV_RST_WORD;
            data_rd_q <= 1'b0;
            data_wr_q <= 1'b0;
            code_rd_q <= 1'b0;
        end else if (ce_i) begin
            mem_addr_q <= mem_addr_d;
            data_rd_q <= sel_valid && !sel_cptr && ptr_rd_i;
            data_wr_q <= sel_valid && !sel_cptr && ptr_wr_i;
            code_rd_q <= sel_cptr && ptr_rd_i;
        end
    end

    // read mux; unmapped addresses read as zero
    always @* begin
        rdata_d = `CPBV_RST_WORD;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `CPBV_ADDR_ACC: begin
                    rdata_d = acc_q;
                end
                `CPBV_ADDR_BASE: begin
                    rdata_d = base_q;
                end
                `CPBV_ADDR_OFST: begin
                    rdata_d = {{(WIDTH-BW){1'b0}}, ofst_q};
                end
                `CPBV_ADDR_MODE: begin
                    rdata_d = {{(WIDTH-`CPBV_MODE_W){1'b0}}, mode_q};
                end
                `CPBV_ADDR_SWAP: begin
                    rdata_d = swapped_view; // RULE1
                end
                `CPBV_ADDR_HIGH: begin
                    rdata_d = {{(WIDTH-BW){1'b0}}, high_byte_view}; // RULE3
                end
                `CPBV_ADDR_SEXT: begin
                    rdata_d = sign_ext_view; // RULE5
                end
                `CPBV_ADDR_FRAME: begin
                    rdata_d = frame_view; // RULE6
                end
                `CPBV_ADDR_DP0: begin
                    rdata_d = ptr_flat[WIDTH-1:0];
                end
                `CPBV_ADDR_DP1: begin
                    rdata_d = ptr_flat[2*WIDTH-1:WIDTH];
                end
                `CPBV_ADDR_CPTR: begin
                    rdata_d = ptr_flat[3*WIDTH-1:2*WIDTH];
                end
                default: begin
                    rdata_d = `CPBV_RST_WORD;
                end
            endcase
        end
    end

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= `CPBV_RST_WORD; // RULE2
        end else if (ce_i) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign mem_addr_o = mem_addr_q;
    assign data_mem_rd_o = data_rd_q;
    assign data_mem_wr_o = data_wr_q;
    assign code_mem_rd_o = code_rd_q;
    assign accum_o = acc_q;
    assign frame_addr_o = frame_view;
endmodule // cpbv_regs

// *** test/cpbv_regs_checker.sv ***
`timescale 1ns/1ps
module cpbv_checker #(
    parameter WIDTH = 16
) (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire [8:0] reg_addr_i,
    input wire [WIDTH-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [WIDTH-1:0] reg_rdata_o,
    input wire [1:0] ptr_sel_i,
    input wire ptr_rd_i,
    input wire ptr_wr_i,
    input wire [WIDTH-1:0] mem_addr_o,
    input wire data_mem_rd_o,
    input wire data_mem_wr_o,
    input wire code_mem_rd_o,
    input wire [WIDTH-1:0] accum_o,
    input wire [WIDTH-1:0] frame_addr_o,
    input wire [WIDTH-1:0] data_ptr0_o,
    input wire [WIDTH-1:0] data_ptr1_o,
    input wire [WIDTH-1:0] code_ptr_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire rd_ok = ce_i && reg_rd_i;
    wire wr_ok = ce_i && reg_wr_i;
    wire pa_ok = ce_i && !reg_wr_i;
    a_rdata_idle: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not cleared");
    a_swap_read: assert property (rd_ok && reg_addr_i == 9'h1C8 |=>
        reg_rdata_o == {$past(accum_o[7:0]), $past(accum_o[15:8])}) else $error("swap view");
    a_high_read: assert property (rd_ok && reg_addr_i == 9'h1C9 |=>
        reg_rdata_o == {8'h00, $past(accum_o[15:8])}) else $error("high alias read");
    a_sext_read: assert property (rd_ok && reg_addr_i == 9'h1CA |=>
        reg_rdata_o == {{8{$past(accum_o[7])}}, $past(accum_o[7:0])}) else $error("sign view");
    a_frame_read: assert property (rd_ok && reg_addr_i == 9'h1CB |=>
        reg_rdata_o == $past(frame_addr_o)) else $error("frame view");
    a_high_write: assert property (wr_ok && reg_addr_i == 9'h1C9 |=>
        accum_o == {$past(reg_wdata_i[7:0]), $past(accum_o[7:0])}) else $error("high write");
    a_ro_write: assert property (wr_ok && reg_addr_i inside {9'h1C8, 9'h1CA, 9'h1CB} |=>
        $stable(accum_o) && $stable(frame_addr_o)) else $error("view write had effect");
    a_reset_clear: assert property ($fell(sys_rst_i) |-> accum_o == 16'h0000 &&
        data_ptr0_o == 16'h0000 && data_ptr1_o == 16'h0000 && code_ptr_o == 16'h0000 &&
        frame_addr_o == 16'h0000 && reg_rdata_o == 16'h0000) else $error("reset state");
    a_dp0_read: assert property (pa_ok && ptr_rd_i && ptr_sel_i == 2'h0 |=>
        data_mem_rd_o && mem_addr_o == $past(data_ptr0_o)) else $error("dp0 read addr");
    a_dp0_write: assert property (pa_ok && ptr_wr_i && ptr_sel_i == 2'h0 |=>
        data_mem_wr_o && mem_addr_o == data_ptr0_o) else $error("dp0 write addr");
    a_dp1_read: assert property (pa_ok && ptr_rd_i && ptr_sel_i == 2'h1 |=>
        data_mem_rd_o && mem_addr_o == $past(data_ptr1_o)) else $error("dp1 read addr");
    a_code_nowrite: assert property (pa_ok && ptr_wr_i && ptr_sel_i == 2'h2 |=>
        $stable(code_ptr_o) && !data_mem_wr_o) else $error("code ptr moved on write");
    c_swap: cover property (rd_ok && reg_addr_i == 9'h1C8);
    c_dwrite: cover property (data_mem_wr_o);
    c_cread: cover property (code_mem_rd_o);
endmodule // cpbv_checker

bind cpbv_regs cpbv_checker #(.WIDTH(WIDTH)) u_chk (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ptr_sel_i(ptr_sel_i),
    .ptr_rd_i(ptr_rd_i), .ptr_wr_i(ptr_wr_i), .mem_addr_o(mem_addr_o),
    .data_mem_rd_o(data_mem_rd_o), .data_mem_wr_o(data_mem_wr_o),
    .code_mem_rd_o(code_mem_rd_o), .accum_o(accum_o), .frame_addr_o(frame_addr_o),
    .data_ptr0_o(data_ptr0_o), .data_ptr1_o(data_ptr1_o), .code_ptr_o(code_ptr_o));

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    localparam [8:0] ad_acc = 9'h180, ad_base = 9'h181, ad_ofsr = 9'h182, ad_mode = 9'h183;
    localparam [8:0] ad_swap = 9'h1C8, ad_hi = 9'h1C9, ad_sx = 9'h1CA, ad_frm = 9'h1CB;
    localparam [8:0] ad_dp0 = 9'h1E3, ad_dp1 = 9'h1E7, ad_cptr = 9'h1EB;
    localparam [71:0] ad_list = {ad_acc, ad_swap, ad_hi, ad_sx, ad_frm, ad_dp0, ad_dp1, ad_cptr};
    reg core_clk_i, sys_rst_i, ce_i, reg_wr_i, reg_rd_i, ptr_rd_i, ptr_wr_i;
    reg [8:0] reg_addr_i;
    reg [15:0] reg_wdata_i;
    reg [1:0] ptr_sel_i;
    wire [15:0] reg_rdata_o, mem_addr_o, accum_o, frame_addr_o, dp0, dp1, cpo;
    wire dmr, dmw, cmr;
    integer errors = 0;
    integer checked = 0;
    integer i;
    cpbv_regs #(.WIDTH(16)) dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ptr_sel_i(ptr_sel_i),
        .ptr_rd_i(ptr_rd_i), .ptr_wr_i(ptr_wr_i), .mem_addr_o(mem_addr_o),
        .data_mem_rd_o(dmr), .data_mem_wr_o(dmw), .code_mem_rd_o(cmr), .accum_o(accum_o),
        .frame_addr_o(frame_addr_o), .data_ptr0_o(dp0), .data_ptr1_o(dp1), .code_ptr_o(cpo));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [8:0] a, input [15:0] d);
        begin
            @(posedge core_clk_i);
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_wr_i <= 1'b1;
            @(posedge core_clk_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    task rdv(input [8:0] a, input [15:0] exp);
        begin
            @(posedge core_clk_i);
            reg_addr_i <= a;
            reg_rd_i <= 1'b1;
            @(posedge core_clk_i);
            reg_rd_i <= 1'b0;
            #1 chk(reg_rdata_o, exp);
        end
    endtask
    // pointer access, then check the address used and the strobe set {data rd, data wr, code rd}
    task pa(input [1:0] sel, input w, input [15:0] ea, input [2:0] es);
        begin
            @(posedge core_clk_i);
            ptr_sel_i <= sel;
            ptr_rd_i <= !w;
            ptr_wr_i <= w;
            @(posedge core_clk_i);
            ptr_rd_i <= 1'b0;
            ptr_wr_i <= 1'b0;
            #1 chk(mem_addr_o, ea);
            chk({13'h0000, dmr, dmw, cmr}, {13'h0000, es});
        end
    endtask
    task zall;
        for (i = 0; i < 8; i = i + 1) rdv(ad_list[i*9+:9], 16'h0000);
    endtask
    task end_sim;
        begin
            if (errors == 0 && checked > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial begin
        #20000;
        errors = errors + 1;
        end_sim;
    end
    initial begin
        {sys_rst_i, ce_i} = 2'b11;
        {reg_wr_i, reg_rd_i, ptr_rd_i, ptr_wr_i, ptr_sel_i} = 6'h00;
        reg_addr_i = 9'h000;
        reg_wdata_i = 16'h0000;
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        zall;
        wr(ad_acc, 16'h1280);
        rdv(ad_swap, 16'h8012);
        rdv(ad_hi, 16'h0012);
        rdv(ad_sx, 16'hFF80);
        wr(ad_acc, 16'h347F);
        rdv(ad_sx, 16'h007F);
        wr(ad_hi, 16'hCDAB);
        rdv(ad_acc, 16'hAB7F);
        wr(ad_base, 16'hFFF0);
        wr(ad_ofsr, 16'h0025);
        rdv(ad_frm, 16'h0015);
        wr(ad_swap, 16'hFFFF);
        wr(ad_sx, 16'hFFFF);
        wr(ad_frm, 16'hFFFF);
        rdv(ad_acc, 16'hAB7F);
        chk(accum_o, 16'hAB7F);
        rdv(ad_frm, 16'h0015);
        chk(frame_addr_o, 16'h0015);
        rdv(ad_swap, 16'h7FAB);
        rdv(9'h1FF, 16'h0000);
        wr(ad_mode, 16'h0019);
        wr(ad_dp0, 16'h0005);
        pa(2'h0, 1'b0, 16'h0005, 3'b100);
        pa(2'h0, 1'b1, 16'h0007, 3'b010);
        rdv(ad_dp0, 16'h0007);
        chk(dp0, 16'h0007);
        wr(ad_dp1, 16'h0000);
        pa(2'h1, 1'b0, 16'h0000, 3'b100);
        pa(2'h1, 1'b1, 16'hFFFE, 3'b010);
        rdv(ad_dp1, 16'hFFFE);
        chk(dp1, 16'hFFFE);
        wr(ad_cptr, 16'h0010);
        pa(2'h2, 1'b0, 16'h0010, 3'b001);
        pa(2'h2, 1'b1, 16'h0010, 3'b000);
        rdv(ad_cptr, 16'h0011);
        wr(ad_mode, 16'h0020);
        pa(2'h2, 1'b0, 16'h0011, 3'b001);
        rdv(ad_cptr, 16'h0010);
        chk(cpo, 16'h0010);
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        wr(ad_acc, 16'h1111);
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        rdv(ad_acc, 16'hAB7F);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        zall;
        chk(mem_addr_o, 16'h0000);
        end_sim;
    end
endmodule // tb_top
